// File: rtl/frame_buffer_overflow_monitor.sv
// frame buffer overflow monitor with apb register slave
// assumes: stream, occupancy and apb come from logic on clk
//
// The register offsets and the APB slave port were left to the implementer.
`include "ovf_mon_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module frame_buffer_overflow_monitor #(
  parameter int DATA_W = 32
) (
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [7:0]          occ_half,
  input  wire logic                in_valid,
  input  wire logic                in_sof,
  input  wire logic                in_eof,
  input  wire logic [DATA_W-1:0]   in_data,
  input  wire logic [15:0]         in_frame_tag,
  output logic                     out_valid,
  output logic                     out_sof,
  output logic                     out_eof,
  output logic                     out_incomplete,
  output logic      [DATA_W-1:0]   out_data,
  output logic                     ev_valid,
  output ovf_mon_pkg::ev_s         ev_data,
  output logic      [31:0]         ev_time,
  output logic                     ovf_state
);

  generate
    if (DATA_W < 1) begin : g_bad_width
      $error("DATA_W must be at least 1");
    end
  endgenerate

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                   ovf_abort;
    logic                   ovf_sync;
    logic                   flag;
    logic [7:0]             rel_lvl;
    logic [7:0]             abort_lvl;
    logic [7:0]             bound_lvl;
    ovf_mon_pkg::filter_t   filter;
    logic                   busy;
    logic                   lost;
    logic                   trunc;
    logic [15:0]            tag;
    logic [31:0]            ts;
    logic                   ev_valid;
    ovf_mon_pkg::ev_s       ev;
    logic [31:0]            ev_time;
    logic                   out_valid;
    logic                   out_sof;
    logic                   out_eof;
    logic                   out_inc;
    logic [DATA_W-1:0]      out_data;
    logic                   ovf_out;
    logic                   pready;
    logic                   pslverr;
    logic [31:0]            prdata;
  } state_s;

  localparam state_s ST_RST = '{
    rel_lvl:   `RST_RELEASE,
    abort_lvl: `RST_ABORT,
    bound_lvl: `RST_BOUND,
    filter:    `RST_FILTER,
    default:   '0
  };

  state_s s_ff;
  state_s nxt_s;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic report_hit(input ovf_mon_pkg::filter_t f,
                                      input logic t, input logic l);
    logic c;
    c = !t && !l;
    unique case (f)
      `F_TRUNC:      report_hit = t;
      `F_LOST:       report_hit = l;
      `F_BAD:        report_hit = t | l;
      `F_GOOD:       report_hit = c;
      `F_TRUNC_GOOD: report_hit = t | c;
      `F_LOST_GOOD:  report_hit = l | c;
      `F_ALL:        report_hit = 1'b1;
      default:       report_hit = 1'b0;
    endcase
  endfunction

  // writes above 100 percent saturate so compares stay meaningful
  function automatic logic [7:0] clamp_lvl(input logic [7:0] v);
    clamp_lvl = (v > `LVL_FULL) ? `LVL_FULL : v;
  endfunction

  function automatic logic reg_known(input logic [7:0] a);
    reg_known = (a == `OFS_FLAG) || (a == `OFS_RELEASE) ||
                (a == `OFS_ABORT) || (a == `OFS_BOUND) ||
                (a == `OFS_FILTER) || (a == `OFS_FILL) ||
                (a == `OFS_STATE);
  endfunction

  logic       full;
  logic       abort_hit;
  logic       bound_hit;
  logic       first;
  logic       at_gap;
  logic       lost_now;
  logic       trunc_now;
  logic       entry;
  logic       acc_first;
  logic       acc_done;
  logic [6:0] fill_pct;

  assign fill_pct = occ_half[7:1];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    nxt_s           = s_ff;
    nxt_s.ts        = s_ff.ts + 32'h1;
    nxt_s.ev_valid  = 1'b0;
    nxt_s.out_valid = 1'b0;
    nxt_s.out_sof   = 1'b0;
    nxt_s.out_eof   = 1'b0;
    nxt_s.out_inc   = 1'b0;
    nxt_s.pready    = 1'b0;
    nxt_s.pslverr   = 1'b0;

    full      = occ_half >= `LVL_FULL;
    abort_hit = (occ_half > s_ff.abort_lvl) || full;
    bound_hit = occ_half > s_ff.bound_lvl;
    first     = in_valid && in_sof;
    at_gap    = (!s_ff.busy && !first) || (in_valid && in_eof && (s_ff.busy || first));

    // abort level acts at once, with hysteresis down to release
    if (abort_hit) begin
      nxt_s.ovf_abort = 1'b1;
    end else if (occ_half < s_ff.rel_lvl) begin
      nxt_s.ovf_abort = 1'b0;
    end
    // boundary level waits for the frame in flight to finish
    if (bound_hit && at_gap) begin
      nxt_s.ovf_sync = 1'b1;
    end else if (occ_half < s_ff.bound_lvl) begin
      nxt_s.ovf_sync = 1'b0;
    end
    nxt_s.ovf_out = nxt_s.ovf_abort || nxt_s.ovf_sync;
    entry = nxt_s.ovf_out && !s_ff.ovf_out;

    // a frame whose first word meets overflow is dropped whole
    lost_now  = first ? (s_ff.ovf_out || abort_hit) : s_ff.lost;
    trunc_now = first ? 1'b0 : s_ff.trunc;
    if (first) begin
      nxt_s.tag = in_frame_tag;
    end
    if (in_valid && (s_ff.busy || first)) begin
      if (!lost_now && abort_hit) begin
        trunc_now = 1'b1;
      end
      nxt_s.out_valid = !lost_now && !trunc_now;
      nxt_s.out_data  = in_data;
      nxt_s.out_sof   = first && !lost_now;
      nxt_s.lost      = lost_now;
      nxt_s.trunc     = trunc_now;
      nxt_s.busy      = !in_eof;
      if (in_eof) begin
        // truncated frames still close on the output, tagged incomplete
        nxt_s.out_eof = !lost_now;
        nxt_s.out_inc = trunc_now;
        if (report_hit(s_ff.filter, trunc_now, lost_now)) begin
          nxt_s.ev_valid            = 1'b1;
          nxt_s.ev                  = '0;
          nxt_s.ev.report_frame_tag = first ? in_frame_tag : s_ff.tag;
          nxt_s.ev.report_truncated = trunc_now;
          nxt_s.ev.report_dropped   = lost_now;
          nxt_s.ev.report_complete  = !trunc_now && !lost_now;
          nxt_s.ev_time             = s_ff.ts;
        end
      end
    end

    // apb: one wait state, read data and read side effect in first access cycle
    acc_first = psel && penable && !s_ff.pready;
    acc_done  = psel && penable && s_ff.pready;
    if (acc_first) begin
      nxt_s.pready  = 1'b1;
      nxt_s.pslverr = !reg_known(paddr);
    end
    if (acc_first && !pwrite) begin
      unique case (paddr)
        `OFS_FLAG:    nxt_s.prdata = {31'h0, s_ff.flag};
        `OFS_RELEASE: nxt_s.prdata = {24'h0, s_ff.rel_lvl};
        `OFS_ABORT:   nxt_s.prdata = {24'h0, s_ff.abort_lvl};
        `OFS_BOUND:   nxt_s.prdata = {24'h0, s_ff.bound_lvl};
        `OFS_FILTER:  nxt_s.prdata = {29'h0, s_ff.filter};
        `OFS_FILL:    nxt_s.prdata = {25'h0, fill_pct};
        `OFS_STATE:   nxt_s.prdata = {30'h0, s_ff.ovf_sync, s_ff.ovf_abort};
        default:      nxt_s.prdata = 32'h0;
      endcase
      if (paddr == `OFS_FLAG) begin
        nxt_s.flag = 1'b0;
      end
    end
    if (acc_done && pwrite) begin
      unique case (paddr)
        `OFS_RELEASE: nxt_s.rel_lvl   = clamp_lvl(pwdata[7:0]);
        `OFS_ABORT:   nxt_s.abort_lvl = clamp_lvl(pwdata[7:0]);
        `OFS_BOUND:   nxt_s.bound_lvl = clamp_lvl(pwdata[7:0]);
        `OFS_FILTER: begin
          if (pwdata[2:0] != `F_ILLEGAL) begin
            nxt_s.filter = pwdata[2:0];
          end
        end
        default: ;
      endcase
    end
    // placed after the read clear so a new overflow wins
    if (entry) begin
      nxt_s.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= ST_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata         = s_ff.prdata;
  assign pready         = s_ff.pready;
  assign pslverr        = s_ff.pslverr;
  assign out_valid      = s_ff.out_valid;
  assign out_sof        = s_ff.out_sof;
  assign out_eof        = s_ff.out_eof;
  assign out_incomplete = s_ff.out_inc;
  assign out_data       = s_ff.out_data;
  assign ev_valid       = s_ff.ev_valid;
  assign ev_data        = s_ff.ev;
  assign ev_time        = s_ff.ev_time;
  assign ovf_state      = s_ff.ovf_out;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  flag_set_a: assert property ($rose(s_ff.ovf_out) |-> s_ff.flag)
    else $error("flag not set on overflow entry");
  flag_clear_a: assert property (acc_first && !pwrite && paddr == `OFS_FLAG && !entry
                                 |=> !s_ff.flag)
    else $error("flag not cleared by read");
  release_exit_a: assert property (s_ff.ovf_abort && occ_half < s_ff.rel_lvl && !abort_hit
                                   |=> !s_ff.ovf_abort)
    else $error("abort overflow kept below release level");
  abort_enter_a: assert property (occ_half > s_ff.abort_lvl |=> s_ff.ovf_abort && ovf_state)
    else $error("abort level did not enter overflow");
  lost_frame_a: assert property (first && ovf_state
                                 |=> !out_valid && !out_sof && !out_eof)
    else $error("frame started in overflow was forwarded");
  trunc_stop_a: assert property (in_valid && s_ff.busy && !s_ff.lost && abort_hit
                                 |=> !out_valid)
    else $error("write not stopped at abort level");
  sync_gap_a: assert property (s_ff.busy && !(in_valid && in_eof) && !s_ff.ovf_sync
                               |=> !s_ff.ovf_sync)
    else $error("boundary overflow entered mid-frame");
  sync_release_a: assert property (occ_half < s_ff.bound_lvl |=> !s_ff.ovf_sync)
    else $error("boundary overflow kept below its level");
  level_range_a: assert property (s_ff.rel_lvl <= `LVL_FULL && s_ff.abort_lvl <= `LVL_FULL
                                  && s_ff.bound_lvl <= `LVL_FULL)
    else $error("level above full scale");
  filter_bad_a: assert property (ev_valid && s_ff.filter == `F_BAD
                                 |-> !ev_data.report_complete)
    else $error("complete frame reported under bad-only filter");
  ev_mask_a: assert property (ev_valid |-> $onehot({ev_data.report_truncated,
                              ev_data.report_dropped, ev_data.report_complete})
                              && ev_data.rsv_mask == 13'h0)
    else $error("event outcome mask malformed");
  ev_tag_a: assert property (ev_valid |-> ev_data.report_frame_tag == s_ff.tag)
    else $error("event frame tag mismatch");
  inc_eof_a: assert property (out_incomplete |-> out_eof && !out_valid)
    else $error("incomplete mark without frame end");
  full_drop_a: assert property (full && in_valid |=> !out_valid)
    else $error("data stored at full capacity");
  fill_read_a: assert property (acc_first && !pwrite && paddr == `OFS_FILL
                                |=> prdata == {25'h0, $past(fill_pct)})
    else $error("fill level read wrong");

  lost_ev_c:  cover property (ev_valid && ev_data.report_dropped);
  trunc_ev_c: cover property (ev_valid && ev_data.report_truncated);
  sync_in_c:  cover property ($rose(s_ff.ovf_sync) && !s_ff.ovf_abort);
  flag_rd_c:  cover property (acc_first && !pwrite && paddr == `OFS_FLAG && s_ff.flag);

endmodule // frame_buffer_overflow_monitor
`default_nettype wire

// File: rtl/ovf_mon_consts.svh
// constants of the frame buffer overflow monitor
// assumes: included by bare name from rtl/
`ifndef OVF_MON_CONSTS_SVH
`define OVF_MON_CONSTS_SVH
// apb byte offsets
`define OFS_FLAG    8'h00
`define OFS_RELEASE 8'h04
`define OFS_ABORT   8'h08
`define OFS_BOUND   8'h0c
`define OFS_FILTER  8'h10
`define OFS_FILL    8'h14
`define OFS_STATE   8'h18
// levels in half-percent steps, 8'hc8 is 100 percent
`define LVL_FULL    8'hc8
`define RST_RELEASE 8'h64
`define RST_ABORT   8'hc7
`define RST_BOUND   8'ha0
// report filter codes
`define F_TRUNC      3'h0
`define F_LOST       3'h1
`define F_BAD        3'h2
`define F_GOOD       3'h3
`define F_TRUNC_GOOD 3'h4
`define F_LOST_GOOD  3'h5
`define F_ALL        3'h6
`define F_ILLEGAL    3'h7
`define RST_FILTER   `F_BAD
`endif

// File: rtl/ovf_mon_pkg.sv
// types of the frame buffer overflow monitor
// assumes: nothing
package ovf_mon_pkg;
  typedef logic [2:0] filter_t;
  // 64-bit event payload, lsb first from the bottom
  typedef struct packed {
    logic [15:0] rsv_hi;
    logic [12:0] rsv_mask;
    logic        report_complete;
    logic        report_dropped;
    logic        report_truncated;
    logic [15:0] rsv_lo;
    logic [15:0] report_frame_tag;
  } ev_s;
endpackage

// File: testbench/stream_partner.sv
// camera stream source and dma sink model for the overflow monitor
// assumes: the bench calls send_frame right after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none

module stream_partner #(
  parameter int DATA_W = 32
) (
  input  wire logic              clk,
  output logic                   in_valid,
  output logic                   in_sof,
  output logic                   in_eof,
  output logic      [DATA_W-1:0] in_data,
  output logic      [15:0]       in_frame_tag,
  input  wire logic              out_valid,
  input  wire logic              out_sof,
  input  wire logic [DATA_W-1:0] out_data,
  input  wire logic              out_eof,
  input  wire logic              out_incomplete,
  input  wire logic              ev_valid,
  input  wire ovf_mon_pkg::ev_s  ev_data
);
  int               n_words  = 0;
  int               n_ev     = 0;
  int               n_sof    = 0;
  int               n_bad    = 0;
  int               idx      = 0;
  logic             cur_tag0 = 1'b0;
  logic             last_inc = 1'b0;
  ovf_mon_pkg::ev_s last_ev  = '0;

  initial begin
    in_valid     = 1'b0;
    in_sof       = 1'b0;
    in_eof       = 1'b0;
    in_data      = '0;
    in_frame_tag = 16'h0000;
  end

  // ****************************************
  // source: one word per cycle, sof to eof
  // ****************************************
  task automatic send_frame(input logic [15:0] tag, input int n);
    cur_tag0 = tag[0];
    for (int k = 0; k < n; k++) begin
      in_valid     <= 1'b1;
      in_sof       <= (k == 0);
      in_eof       <= (k == n - 1);
      in_data      <= DATA_W'(k) ^ {DATA_W{tag[0]}};
      in_frame_tag <= tag;
      @(posedge clk);
    end
    // released data and tag lines flip so a stale word never looks like a held one
    in_valid     <= 1'b0;
    in_sof       <= 1'b0;
    in_eof       <= 1'b0;
    in_data      <= ~in_data;
    in_frame_tag <= ~in_frame_tag;
  endtask

  // sink counts forwarded words and keeps the latest event
  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      n_words <= n_words + 1;
      idx     <= (out_sof === 1'b1) ? 1 : idx + 1;
      if (out_sof === 1'b1) n_sof <= n_sof + 1;
      // forwarded words must keep their order and value
      if (out_data !== (DATA_W'((out_sof === 1'b1) ? 0 : idx) ^ {DATA_W{cur_tag0}})) n_bad <= n_bad + 1;
    end
    if (out_eof === 1'b1) last_inc <= out_incomplete;
    if (ev_valid === 1'b1) begin
      last_ev <= ev_data;
      n_ev    <= n_ev + 1;
    end
  end
endmodule // stream_partner
`default_nettype wire

// File: testbench/frame_buffer_overflow_monitor_tb.sv
// self-checking bench for the frame buffer overflow monitor
// assumes: ovf_mon_consts.svh on the include path, stream_partner compiled first
`include "ovf_mon_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module frame_buffer_overflow_monitor_tb;
  logic             clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]       paddr, occ_half, lvl;
  logic [31:0]      pwdata, prdata, ev_time, rd, seed, in_data, out_data;
  logic             in_valid, in_sof, in_eof, out_valid, out_sof, out_eof, out_incomplete, ev_valid, ovf_state;
  logic [15:0]      in_frame_tag;
  ovf_mon_pkg::ev_s ev_data;
  int               n_fail = 0;
  int               n_checks = 0;
  int               cyc = 0;

  frame_buffer_overflow_monitor #(.DATA_W(32)) dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .occ_half(occ_half), .in_valid(in_valid), .in_sof(in_sof), .in_eof(in_eof), .in_data(in_data),
    .in_frame_tag(in_frame_tag), .out_valid(out_valid), .out_sof(out_sof), .out_eof(out_eof),
    .out_incomplete(out_incomplete), .out_data(out_data), .ev_valid(ev_valid), .ev_data(ev_data),
    .ev_time(ev_time), .ovf_state(ovf_state));

  stream_partner #(.DATA_W(32)) pm (.clk(clk), .in_valid(in_valid), .in_sof(in_sof), .in_eof(in_eof),
    .in_data(in_data), .in_frame_tag(in_frame_tag), .out_valid(out_valid), .out_sof(out_sof),
    .out_data(out_data), .out_eof(out_eof),
    .out_incomplete(out_incomplete), .ev_valid(ev_valid), .ev_data(ev_data));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // mirrors the event timestamp: counts edges taken out of reset
  always @(posedge clk) begin
    if (rst_b === 1'b1) cyc <= cyc + 1;
  end

  // ****************************************
  // reporting, bus cycles, expectations
  // ****************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  // k holds {complete, lost, truncated}
  function automatic logic [63:0] exp_ev(input logic [2:0] k, input logic [15:0] t);
    return {29'h0, k, 16'h0, t};
  endfunction

  function automatic logic wants(input logic [2:0] f, input logic [2:0] k);
    logic [2:0] m;
    case (f)
      3'h0: m = 3'b001;
      3'h1: m = 3'b010;
      3'h2: m = 3'b011;
      3'h3: m = 3'b100;
      3'h4: m = 3'b101;
      3'h5: m = 3'b110;
      default: m = 3'b111;
    endcase
    return |(m & k);
  endfunction

  // one frame; occupancy jumps to occ_cut after cut words when cut is nonzero
  task automatic run(input logic [2:0] f, input logic [2:0] k, input logic [15:0] t, input int n,
                     input int cut, input logic [7:0] occ_cut, input int words);
    int w0;
    int e0;
    int s0;
    int c0;
    w0 = pm.n_words;
    e0 = pm.n_ev;
    s0 = pm.n_sof;
    fork
      pm.send_frame(t, n);
      begin
        if (cut > 0) begin
          repeat (cut) @(posedge clk);
          occ_half <= occ_cut;
        end
      end
    join
    c0 = cyc;
    repeat (3) @(posedge clk);
    check(64'(pm.n_words - w0), 64'(words));
    check(64'(pm.n_sof - s0), 64'(words > 0));
    check(64'(pm.n_bad), 64'h0);
    if (wants(f, k)) check(64'(ev_time), 64'(c0));
    check(64'(pm.n_ev - e0), 64'(wants(f, k)));
    if (wants(f, k)) check(pm.last_ev, exp_ev(k, t));
    if (k == 3'b001) check(pm.last_inc, 1'b1);
    $display("test frame kind %b filter %0d done", k, f);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed     = 32'hdbf2207c;
    rst_b    = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    occ_half = 8'h00;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, `OFS_RELEASE, 32'h0);
    check(rd, 64'(`RST_RELEASE));
    apb(1'b0, `OFS_ABORT, 32'h0);
    check(rd, 64'(`RST_ABORT));
    apb(1'b0, `OFS_BOUND, 32'h0);
    check(rd, 64'(`RST_BOUND));
    apb(1'b0, `OFS_FILTER, 32'h0);
    check(rd, 64'(`RST_FILTER));
    apb(1'b0, `OFS_FLAG, 32'h0);
    check(rd, 64'h0);
    apb(1'b0, 8'h1c, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b1, `OFS_ABORT, 32'h0000_00ff);
    apb(1'b0, `OFS_ABORT, 32'h0);
    check(rd, 64'(`LVL_FULL));
    apb(1'b1, `OFS_ABORT, 32'(`RST_ABORT));
    apb(1'b1, `OFS_FILTER, 32'(`F_ILLEGAL));
    apb(1'b0, `OFS_FILTER, 32'h0);
    check(rd, 64'(`RST_FILTER));
    lvl = 8'({$random(seed)} % 201);
    occ_half <= lvl;
    apb(1'b0, `OFS_FILL, 32'h0);
    check(rd, 64'(lvl >> 1));
    $display("test registers done");
    for (int f = 0; f < 7; f++) begin
      apb(1'b1, `OFS_FILTER, 32'(f));
      occ_half <= 8'({$random(seed)} % 100);
      run(3'(f), 3'b100, 16'($random(seed)), 4 + f, 0, 8'h00, 4 + f);
      run(3'(f), 3'b001, 16'($random(seed)), 8, 3, `LVL_FULL, 3);
      check(ovf_state, 1'b1);
      apb(1'b0, `OFS_FLAG, 32'h0);
      check(rd, 64'h1);
      apb(1'b0, `OFS_FLAG, 32'h0);
      check(rd, 64'h0);
      run(3'(f), 3'b010, 16'($random(seed)), 5, 0, 8'h00, 0);
      occ_half <= `RST_RELEASE;
      repeat (3) @(posedge clk);
      check(ovf_state, 1'b1);
      occ_half <= `RST_RELEASE - 8'h01;
      repeat (3) @(posedge clk);
      check(ovf_state, 1'b0);
    end
    // a frame at tag ffff crosses the boundary level mid-frame and still completes whole
    run(3'h6, 3'b100, 16'hffff, 6, 2, `RST_BOUND + 8'h01, 6);
    check(ovf_state, 1'b1);
    run(3'h6, 3'b010, 16'h0000, 3, 0, 8'h00, 0);
    occ_half <= `RST_BOUND;
    repeat (3) @(posedge clk);
    check(ovf_state, 1'b1);
    occ_half <= `RST_BOUND - 8'h01;
    repeat (3) @(posedge clk);
    check(ovf_state, 1'b0);
    $display("test frame boundary done");
    give_verdict();
  end

  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    give_verdict();
  end
endmodule // frame_buffer_overflow_monitor_tb
`default_nettype wire
